/* File: hdl/mpgpio_pkg.sv */
// Package of register map, port masks and reset values for the GPIO block
`default_nettype none
package mpgpio_pkg;
   // Register indices on the plain register port
   localparam logic [3:0] MPG_ADDR_A_DATA = 4'h0;
   localparam logic [3:0] MPG_ADDR_A_DIR  = 4'h1;
   localparam logic [3:0] MPG_ADDR_A_ALT  = 4'h2;
   localparam logic [3:0] MPG_ADDR_B_PINS = 4'h3;
   localparam logic [3:0] MPG_ADDR_C_DATA = 4'h4;
   localparam logic [3:0] MPG_ADDR_C_DIR  = 4'h5;
   localparam logic [3:0] MPG_ADDR_C_ALT  = 4'h6;
   localparam logic [3:0] MPG_ADDR_D_DATA = 4'h8;
   localparam logic [3:0] MPG_ADDR_D_DIR  = 4'h9;
   localparam logic [3:0] MPG_ADDR_D_ALT  = 4'ha;
   // Physical bit masks of each port
   localparam logic [7:0] MPG_MASK_A      = 8'h0f;
   localparam logic [7:0] MPG_MASK_C      = 8'hc7;
   localparam logic [7:0] MPG_MASK_D      = 8'h0f;
   // Bits whose alternate output is forced low
   localparam logic [7:0] MPG_FORCE0_A    = 8'h03;
   localparam logic [7:0] MPG_FORCE0_C    = 8'h04;
   localparam logic [7:0] MPG_FORCE0_D    = 8'h01;
   // Value after reset of all control registers
   localparam logic [7:0] MPG_RST_VAL     = 8'h00;
endpackage : mpgpio_pkg
`default_nettype wire

/* File: hdl/mpgpio_port.sv */
// One bidirectional port: data, direction and alternate registers with pin muxing
`default_nettype none
module mpgpio_port
   import mpgpio_pkg::*;
#(
   parameter logic [7:0] MASK   = 8'hff,   // Physical bits
   parameter logic [7:0] FORCE0 = 8'h00    // Alternate outputs forced low
)(
   input  wire logic       sys_clk,        // System clock
   input  wire logic       rst_n,          // Async reset, active low
   input  wire logic       wr_data,        // Write data register
   input  wire logic       wr_dir,         // Write direction register
   input  wire logic       wr_alt,         // Write alternate register
   input  wire logic [7:0] wdata,          // Write data
   input  wire logic [7:0] pin_in,         // Pin levels
   input  wire logic [7:0] periph_out,     // Peripheral output values
   output logic      [7:0] pin_out,        // Pin output level
   output logic      [7:0] pin_oe_n,       // Output enable, low drives
   output logic      [7:0] pull_up,        // Pull-up enable
   output logic      [7:0] rd_data,        // Per-bit read selection
   output logic      [7:0] dir_q,          // Direction register
   output logic      [7:0] alt_q           // Alternate register
);
   logic [7:0] data_q;                     // Data register
   logic [7:0] alt_val;                    // Alternate output value

   // Data register always stores writes, whatever the mode
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         data_q <= MPG_RST_VAL;
      else if (wr_data)
         data_q <= wdata & MASK;
   end

   // Direction register
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         dir_q <= MPG_RST_VAL;
      else if (wr_dir)
         dir_q <= wdata & MASK;
   end

   // Alternate-function register
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         alt_q <= MPG_RST_VAL;
      else if (wr_alt)
         alt_q <= wdata & MASK;
   end

   // Forced bits give 0 as alternate output
   assign alt_val  = periph_out & ~FORCE0 & MASK;
   // Output source: data or peripheral
   assign pin_out  = ((dir_q & ~alt_q & data_q) | (dir_q & alt_q & alt_val)) & MASK;
   // Drive only where direction is output; reset leaves all high impedance
   assign pin_oe_n = ~(dir_q & MASK);
   // Pull-up on inputs with alternate bit set
   assign pull_up  = ~dir_q & alt_q & MASK;
   // Read: pin, data or alternate value; missing bits read 0
   assign rd_data  = ((~dir_q & pin_in) | (dir_q & ~alt_q & data_q)
                     | (dir_q & alt_q & alt_val)) & MASK;
endmodule : mpgpio_port
`default_nettype wire

/* File: hdl/mpgpio_top.sv */
// Top of the multi-port GPIO block: register port, ports A to D
`default_nettype none
// Functional notes
// - Port A four bits, per-bit direction
// - Output with alt clear drives data bit
// - Output with alt set drives peripheral
// - Alternate input shares pin input path
// - Input with alt set enables pull-up
// - Port A bits 0,1 alternate drive 0
// - Reset clears all registers, inputs
// - Read picks pin, data or alternate
// - Missing bits read as zero
// - Read-modify-write uses read selection
// - Port B eight input-only bits
// - Port B has no pull-ups
// - Port B pins feed analog converter
// - Port A alternate function assignments
// - Port C alternate function assignments
// - Port D alternate function assignments
module mpgpio_top
   import mpgpio_pkg::*;
(
   input  wire logic       sys_clk,               // System clock
   input  wire logic       rst_n,                 // Async reset, active low
   input  wire logic [3:0] reg_addr,              // Register index
   input  wire logic [7:0] reg_wdata,             // Write data
   input  wire logic       reg_wr,                // Write strobe
   input  wire logic       reg_rd,                // Read strobe
   output logic      [7:0] reg_rdata,             // Read data, cycle after strobe
   input  wire logic [3:0] port_a_in,             // Port A pin levels
   output logic      [3:0] port_a_out,            // Port A pin drive
   output logic      [3:0] port_a_oe_n,           // Port A enable, low drives
   output logic      [3:0] port_a_pull_up,        // Port A pull-ups
   input  wire logic [7:0] port_b_in,             // Port B pin levels
   output logic      [7:0] analog_in_channel,     // Port B to converter
   input  wire logic [4:0] port_c_in,             // Port C pins 0,1,2,6,7
   output logic      [4:0] port_c_out,            // Port C pin drive
   output logic      [4:0] port_c_oe_n,           // Port C enable, low drives
   output logic      [4:0] port_c_pull_up,        // Port C pull-ups
   input  wire logic [3:0] port_d_in,             // Port D pin levels
   output logic      [3:0] port_d_out,            // Port D pin drive
   output logic      [3:0] port_d_oe_n,           // Port D enable, low drives
   output logic      [3:0] port_d_pull_up,        // Port D pull-ups
   input  wire logic       system_clock_out,      // Peripheral: clock out
   input  wire logic       subclock_out,          // Peripheral: subclock out
   output logic            bus_wait_request,      // Alternate input A0
   output logic            bus_hold_request,      // Alternate input A1
   input  wire logic       serial_c_clock_out,    // Serial clock, output side
   output logic            serial_c_clock_in,     // Serial clock, input side
   input  wire logic       serial_c_data_out,     // Serial data out
   output logic            serial_c_data_in,      // Serial data in
   input  wire logic       analog_out_ch0,        // Analog out channel 0
   input  wire logic       analog_out_ch1,        // Analog out channel 1
   output logic            async_d_receive_in,    // Async receive data in
   input  wire logic       async_d_transmit_out,  // Async transmit data
   input  wire logic       async_d_rx_clock_out,  // Receive clock, output side
   output logic            async_d_receive_clock, // Receive clock, input side
   input  wire logic       async_d_tx_clock_out,  // Transmit clock, output side
   output logic            async_d_transmit_clock // Transmit clock, input side
);
   logic [7:0] a_pin, c_pin, d_pin;               // Pins in register bit order
   logic [7:0] a_per, c_per, d_per;               // Peripheral outputs by bit
   logic [7:0] a_o, c_o, d_o;                     // Pin drive by bit
   logic [7:0] a_oe, c_oe, d_oe;                  // Enables by bit
   logic [7:0] a_pu, c_pu, d_pu;                  // Pull-ups by bit
   logic [7:0] a_rd, c_rd, d_rd;                  // Read selections
   logic       wr_a_data, wr_a_dir, wr_a_alt;     // Write decodes port A
   logic       wr_c_data, wr_c_dir, wr_c_alt;     // Write decodes port C
   logic       wr_d_data, wr_d_dir, wr_d_alt;     // Write decodes port D
   logic [7:0] a_dir, a_alt, c_dir, c_alt, d_dir, d_alt; // Control readback
   logic [7:0] rdata_d;                           // Next read data
   logic [7:0] rdata_q;                           // Read data register

   // Pin gather; port C bits live at 0,1,2,6,7
   assign a_pin = {4'h0, port_a_in};
   assign c_pin = {port_c_in[4:3], 3'h0, port_c_in[2:0]};
   assign d_pin = {4'h0, port_d_in};

   // Peripheral output assignment per bit
   assign a_per = {4'h0, subclock_out, system_clock_out, 2'h0};
   assign c_per = {analog_out_ch1, analog_out_ch0, 3'h0, 1'h0,
                   serial_c_data_out, serial_c_clock_out};
   assign d_per = {4'h0, async_d_tx_clock_out, async_d_rx_clock_out,
                   async_d_transmit_out, 1'h0};

   // Alternate inputs come straight from the pin input path
   assign bus_wait_request       = port_a_in[0];
   assign bus_hold_request       = port_a_in[1];
   assign serial_c_clock_in      = port_c_in[0];
   assign serial_c_data_in       = port_c_in[2];
   assign async_d_receive_in     = port_d_in[0];
   assign async_d_receive_clock  = port_d_in[2];
   assign async_d_transmit_clock = port_d_in[3];

   // Port B passes straight to the converter, no pull-up exists
   assign analog_in_channel = port_b_in;

   // Write strobe decode
   assign wr_a_data = reg_wr && (reg_addr == MPG_ADDR_A_DATA);
   assign wr_a_dir  = reg_wr && (reg_addr == MPG_ADDR_A_DIR);
   assign wr_a_alt  = reg_wr && (reg_addr == MPG_ADDR_A_ALT);
   assign wr_c_data = reg_wr && (reg_addr == MPG_ADDR_C_DATA);
   assign wr_c_dir  = reg_wr && (reg_addr == MPG_ADDR_C_DIR);
   assign wr_c_alt  = reg_wr && (reg_addr == MPG_ADDR_C_ALT);
   assign wr_d_data = reg_wr && (reg_addr == MPG_ADDR_D_DATA);
   assign wr_d_dir  = reg_wr && (reg_addr == MPG_ADDR_D_DIR);
   assign wr_d_alt  = reg_wr && (reg_addr == MPG_ADDR_D_ALT);

   // Port A, four bits, bits 0 and 1 forced low as alternate
   mpgpio_port #(.MASK(MPG_MASK_A), .FORCE0(MPG_FORCE0_A)) u_port_a (
      .sys_clk    (sys_clk),
      .rst_n      (rst_n),
      .wr_data    (wr_a_data),
      .wr_dir     (wr_a_dir),
      .wr_alt     (wr_a_alt),
      .wdata      (reg_wdata),
      .pin_in     (a_pin),
      .periph_out (a_per),
      .pin_out    (a_o),
      .pin_oe_n   (a_oe),
      .pull_up    (a_pu),
      .rd_data    (a_rd),
      .dir_q      (a_dir),
      .alt_q      (a_alt)
   );

   // Port C, five bits, bit 2 forced low as alternate
   mpgpio_port #(.MASK(MPG_MASK_C), .FORCE0(MPG_FORCE0_C)) u_port_c (
      .sys_clk    (sys_clk),
      .rst_n      (rst_n),
      .wr_data    (wr_c_data),
      .wr_dir     (wr_c_dir),
      .wr_alt     (wr_c_alt),
      .wdata      (reg_wdata),
      .pin_in     (c_pin),
      .periph_out (c_per),
      .pin_out    (c_o),
      .pin_oe_n   (c_oe),
      .pull_up    (c_pu),
      .rd_data    (c_rd),
      .dir_q      (c_dir),
      .alt_q      (c_alt)
   );

   // Port D, four bits, bit 0 forced low as alternate
   mpgpio_port #(.MASK(MPG_MASK_D), .FORCE0(MPG_FORCE0_D)) u_port_d (
      .sys_clk    (sys_clk),
      .rst_n      (rst_n),
      .wr_data    (wr_d_data),
      .wr_dir     (wr_d_dir),
      .wr_alt     (wr_d_alt),
      .wdata      (reg_wdata),
      .pin_in     (d_pin),
      .periph_out (d_per),
      .pin_out    (d_o),
      .pin_oe_n   (d_oe),
      .pull_up    (d_pu),
      .rd_data    (d_rd),
      .dir_q      (d_dir),
      .alt_q      (d_alt)
   );

   // Pin scatter back to physical ports
   assign port_a_out     = a_o[3:0];
   assign port_a_oe_n    = a_oe[3:0];
   assign port_a_pull_up = a_pu[3:0];
   assign port_c_out     = {c_o[7:6], c_o[2:0]};
   assign port_c_oe_n    = {c_oe[7:6], c_oe[2:0]};
   assign port_c_pull_up = {c_pu[7:6], c_pu[2:0]};
   assign port_d_out     = d_o[3:0];
   assign port_d_oe_n    = d_oe[3:0];
   assign port_d_pull_up = d_pu[3:0];

   // Read mux; unmapped indices read zero
   always_comb
   begin
      rdata_d = 8'h00;
      unique case (reg_addr)
         MPG_ADDR_A_DATA: rdata_d = a_rd;
         MPG_ADDR_A_DIR:  rdata_d = a_dir;
         MPG_ADDR_A_ALT:  rdata_d = a_alt;
         MPG_ADDR_B_PINS: rdata_d = port_b_in;
         MPG_ADDR_C_DATA: rdata_d = c_rd;
         MPG_ADDR_C_DIR:  rdata_d = c_dir;
         MPG_ADDR_C_ALT:  rdata_d = c_alt;
         MPG_ADDR_D_DATA: rdata_d = d_rd;
         MPG_ADDR_D_DIR:  rdata_d = d_dir;
         MPG_ADDR_D_ALT:  rdata_d = d_alt;
         default:         rdata_d = 8'h00;
      endcase
   end

   // Read data register, loaded on read strobe, cleared to zero in every other cycle
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         rdata_q <= MPG_RST_VAL;
      else if (reg_rd)
         rdata_q <= rdata_d;
      else
         rdata_q <= 8'h00;
   end

   assign reg_rdata = rdata_q;
endmodule : mpgpio_top
`default_nettype wire

/* File: verification/mpgpio_checker.sv */
// Port-level assertions for the multi-port GPIO block
`default_nettype none
module mpgpio_checker
   import mpgpio_pkg::*;
(
   input wire logic       sys_clk,
   input wire logic       rst_n,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic [3:0] port_a_in,
   input wire logic [3:0] port_a_out,
   input wire logic [3:0] port_a_oe_n,
   input wire logic [3:0] port_a_pull_up,
   input wire logic [7:0] port_b_in,
   input wire logic [7:0] analog_in_channel,
   input wire logic       bus_wait_request,
   input wire logic       bus_hold_request
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   // Alternate select, then direction, both on port A bits 0 and 1
   sequence alt_low_s;
      reg_wr && reg_addr == MPG_ADDR_A_ALT && reg_wdata[1:0] == 2'b11;
   endsequence
   sequence dir_low_s;
      reg_wr && reg_addr == MPG_ADDR_A_DIR && reg_wdata[1:0] == 2'b11;
   endsequence
   dir_drive_a: assert property (
      reg_wr && reg_addr == MPG_ADDR_A_DIR |=> port_a_oe_n == ~$past(reg_wdata[3:0]))
      else $error("port A enable differs from direction write");
   forced_low_a: assert property (
      alt_low_s ##2 dir_low_s |=> port_a_out[1:0] == 2'b00 && port_a_oe_n[1:0] == 2'b00)
      else $error("port A bits 0,1 not driven low as alternate outputs");
   idle_rdata_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data not zero outside a read");
   reset_inputs_a: assert property (
      $rose(rst_n) |-> port_a_oe_n == 4'hf && port_a_pull_up == 4'h0)
      else $error("port A not a plain input after reset");
   pullup_input_a: assert property ((port_a_pull_up & ~port_a_oe_n) == 4'h0)
      else $error("pull-up on while driving");
   pins_b_read_a: assert property (
      reg_rd && reg_addr == MPG_ADDR_B_PINS && $stable(port_b_in)
      |=> reg_rdata == $past(port_b_in))
      else $error("port B read differs from pins");
   analog_copy_a: assert property (analog_in_channel == port_b_in)
      else $error("converter channel differs from port B pins");
   alt_input_a: assert property (
      {bus_hold_request, bus_wait_request} == port_a_in[1:0])
      else $error("alternate inputs differ from pins");
   unmapped_zero_a: assert property (
      reg_rd && reg_addr == 4'h7 |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
endmodule : mpgpio_checker
bind mpgpio_top mpgpio_checker checker_i (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
   .reg_rd, .reg_rdata, .port_a_in, .port_a_out, .port_a_oe_n, .port_a_pull_up, .port_b_in,
   .analog_in_channel, .bus_wait_request, .bus_hold_request);
`default_nettype wire

/* File: verification/mpgpio_pin_model.sv */
// Board side of a port: resolves each pad from device drive, board drive and pull-up
`default_nettype none
module mpgpio_pin_model #(
   parameter int W = 4               // Pin count
)(
   input  wire logic         sys_clk, // System clock
   input  wire logic [W-1:0] drv,     // Device drive level
   input  wire logic [W-1:0] oe_n,    // Device enable, low drives
   input  wire logic [W-1:0] pull_up, // Device pull-up enable
   input  wire logic [W-1:0] ext_val, // Board drive level
   input  wire logic [W-1:0] ext_en,  // Board drives the pad
   output logic      [W-1:0] pin      // Resolved pad level
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [W-1:0] float_q = '0;        // Pattern of an undriven pad
   // Undriven pad wanders each cycle, so no stale value passes
   always @(posedge sys_clk)
   begin
      float_q <= ~float_q;
   end
   // Device wins, then board, then pull-up, else floating
   always_comb
   begin
      for (int i = 0; i < W; i++)
      begin
         pin[i] = !oe_n[i] ? drv[i] : ext_en[i] ? ext_val[i] : pull_up[i] ? 1'b1 : float_q[i];
      end
   end
endmodule : mpgpio_pin_model
`default_nettype wire

/* File: verification/testbench.sv */
// Self-checking bench for the multi-port GPIO block
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import mpgpio_pkg::*;
   logic sys_clk, rst_n, reg_wr, reg_rd, bus_wait_request, serial_c_data_in, async_d_receive_in;
   logic [3:0] reg_addr, port_a_in, port_a_out, port_a_oe_n, port_a_pull_up, a_ext, a_en, base;
   logic [3:0] port_d_in, port_d_out, port_d_oe_n, port_d_pull_up, d_ext, d_en;
   logic [4:0] port_c_in, port_c_out, port_c_oe_n, port_c_pull_up, c_ext, c_en;
   logic [7:0] reg_wdata, reg_rdata, port_b_in, analog_in_channel, rv;
   logic system_clock_out, subclock_out, serial_c_clock_out, serial_c_data_out, analog_out_ch0;
   logic analog_out_ch1, async_d_transmit_out, async_d_rx_clock_out, async_d_tx_clock_out;
   int fails, total_checks;
   // Device under test
   mpgpio_top mpgpio_top_i (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .port_a_in, .port_a_out, .port_a_oe_n, .port_a_pull_up, .port_b_in, .analog_in_channel,
      .port_c_in, .port_c_out, .port_c_oe_n, .port_c_pull_up, .port_d_in, .port_d_out,
      .port_d_oe_n, .port_d_pull_up, .system_clock_out, .subclock_out, .bus_wait_request,
      .bus_hold_request(), .serial_c_clock_out, .serial_c_clock_in(), .serial_c_data_out,
      .serial_c_data_in, .analog_out_ch0, .analog_out_ch1, .async_d_receive_in,
      .async_d_transmit_out, .async_d_rx_clock_out, .async_d_receive_clock(),
      .async_d_tx_clock_out, .async_d_transmit_clock());
   // Board pads of ports A, C and D
   mpgpio_pin_model #(.W(4)) pa_i (.sys_clk, .drv(port_a_out), .oe_n(port_a_oe_n),
      .pull_up(port_a_pull_up), .ext_val(a_ext), .ext_en(a_en), .pin(port_a_in));
   mpgpio_pin_model #(.W(5)) pc_i (.sys_clk, .drv(port_c_out), .oe_n(port_c_oe_n),
      .pull_up(port_c_pull_up), .ext_val(c_ext), .ext_en(c_en), .pin(port_c_in));
   mpgpio_pin_model #(.W(4)) pd_i (.sys_clk, .drv(port_d_out), .oe_n(port_d_oe_n),
      .pull_up(port_d_pull_up), .ext_val(d_ext), .ext_en(d_en), .pin(port_d_in));
   // 250 MHz clock
   initial
   begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   // Compare and count
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   // One-cycle register write
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      #1;
   endtask : wr
   // One-cycle read, data checked in the following cycle
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      rv = reg_rdata;
      check(reg_rdata, exp);
   endtask : rd
   // Verdict and end of run
   task automatic tally_and_finish;
      $display("checks=%0d mismatches=%0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : tally_and_finish
   // Main sequence
   initial
   begin
      {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, subclock_out} = '0;
      {system_clock_out, serial_c_clock_out, serial_c_data_out, analog_out_ch0} = 4'hf;
      {analog_out_ch1, async_d_transmit_out, async_d_rx_clock_out, async_d_tx_clock_out} = 4'hf;
      {port_b_in, a_ext, a_en, c_ext, c_en, d_ext, d_en} = {8'h5a, 8'haf, 10'h2bf, 8'h6f};
      repeat (6) @(posedge sys_clk);
      rst_n <= 1'b1;
      #1;
      check({port_a_oe_n, port_d_oe_n}, 8'hff);
      check({6'h0, serial_c_data_in, async_d_receive_in}, 8'h02);
      rd(MPG_ADDR_A_ALT, 8'h00);
      rd(MPG_ADDR_A_DATA, 8'h0a);
      rd(MPG_ADDR_C_DATA, 8'h85);
      wr(MPG_ADDR_A_DATA, 8'hf5);
      rd(MPG_ADDR_A_DATA, 8'h0a);
      wr(MPG_ADDR_A_DIR, 8'hff);
      check({4'h0, port_a_out}, 8'h05);
      rd(MPG_ADDR_A_DIR, 8'h0f);
      // Alternate outputs, then software read-modify-write
      wr(MPG_ADDR_A_DIR, 8'h00);
      wr(MPG_ADDR_A_ALT, 8'h0f);
      wr(MPG_ADDR_A_DIR, 8'h0f);
      check({4'h0, port_a_out}, 8'h04);
      rd(MPG_ADDR_A_DATA, 8'h04);
      wr(MPG_ADDR_A_DATA, rv ^ 8'h03);
      wr(MPG_ADDR_A_ALT, 8'h00);
      rd(MPG_ADDR_A_DATA, 8'h07);
      // Pull-ups on alternate inputs with the board released
      wr(MPG_ADDR_A_DIR, 8'h00);
      wr(MPG_ADDR_A_ALT, 8'h0f);
      @(posedge sys_clk);
      a_en <= 4'h0;
      #1;
      check({port_a_pull_up, port_a_oe_n}, 8'hff);
      rd(MPG_ADDR_A_DATA, 8'h0f);
      // Input-only port and unmapped index
      wr(MPG_ADDR_B_PINS, 8'hff);
      rd(MPG_ADDR_B_PINS, 8'h5a);
      check(analog_in_channel, 8'h5a);
      wr(4'h7, 8'hff);
      rd(4'h7, 8'h00);
      // Ports C and D through alternate and plain output
      for (int p = 0; p < 2; p++)
      begin
         base = p ? MPG_ADDR_D_DATA : MPG_ADDR_C_DATA;
         wr(base, 8'hff);
         wr(base + 4'h2, 8'hff);
         wr(base + 4'h1, 8'hff);
         rd(base + 4'h1, p ? MPG_MASK_D : MPG_MASK_C);
         check(p ? {4'h0, port_d_out} : {3'h0, port_c_out}, p ? 8'h0e : 8'h1b);
         rd(base, p ? 8'h0e : 8'hc3);
         wr(base + 4'h2, 8'h00);
         rd(base, p ? 8'h0f : 8'hc7);
      end
      // Reset in mid-run clears data, direction and select
      @(posedge sys_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      #1;
      check({3'h0, port_c_oe_n}, 8'h1f);
      rd(MPG_ADDR_D_DIR, 8'h00);
      wr(MPG_ADDR_A_DIR, 8'h0f);
      check({4'h0, port_a_out}, 8'h00);
      tally_and_finish();
   end
endmodule : testbench
`default_nettype wire
